// *** src/osd_spi_slave.v ***
// 16-bit spi slave front end with the off-state diagnosis sequencer
// assumes spi pins come from the master asynchronously and that the
// analogue detection inputs and the disable input are synchronous levels
`timescale 1ns/100ps
`include "osd_spi_defs.vh"

// Operation
// (R1) a transfer is 16 bits, or a whole multiple of 16 in a chain
// (R2) command and response words travel most significant bit first
// (R3) the master drives chip select and serial clock, never this device
// (R4) the answer to a command comes out in the following transfer
// (R5) response bits change on serial clock rising edges while selected
// (R6) command bits are captured on serial clock falling edges
// (R7) deselected or in reset: clock and data ignored, output floats
// (R8) the master keeps serial clock low at chip select edges
// (R9) the command executes only when chip select rises after whole words
// (R10) a select with no clock is valid, ignored, keeps the pending answer
// (R11) command is address, eleven data bits, then parity at the bottom
// (R12) response repeats the address, then twelve payload bits
// (R13) the first response after any reset is all zeros
// (R14) bad code, bad parity or partial word gives an all-zero answer
// (R15) settle wait restarts only on disable rising edge or a reset
// (R16) trigger turns sources on, then waits the settling delay
// (R17) combined input must hold still for the filter time; edges restart it
// (R18) a timeout runs beside the filter to end a restless input
// (R19) open load 001, battery short 010, ground short 011, by priority
// (R20) a completed diagnosis without fault reports 100
// (R21) 101 wrong state, 110 settle wait pending, 111 running or reset
// (R22) result sits in payload bits two to zero of the diagnosis answer
// (R23) command parity is odd over all sixteen bits
// (R24) responses carry no parity; all payload bits are data
// (R25) the master starts a diagnosis with the trigger bit set
// (R26) spi pins are synchronised and edges found from the clean samples
module osd_spi_slave #(
	parameter [31:0] THZ_CYCLES   = `OSD_THZ_CYC,
	parameter [31:0] TDEL_CYCLES  = `OSD_TDEL_CYC,
	parameter [31:0] TSTAB_CYCLES = `OSD_TSTAB_CYC,
	parameter [31:0] TOUT_CYCLES  = `OSD_TOUT_CYC
) (
	input  wire       clock,
	input  wire       rstn,
	input  wire       sw_reset,
	input  wire       spi_cs_n,
	input  wire       spi_sclk,
	input  wire       spi_sdi,
	output wire       spi_sdo,
	output wire       spi_sdo_oe,
	input  wire       disable_input,
	input  wire       supply_undervoltage,
	input  wire       open_load_det,
	input  wire       short_to_battery,
	input  wire       short_to_ground,
	output wire       diag_sources_on,
	output wire [2:0] off_state_diag_result,
	output wire       comm_error,
	output wire       offstate_trigger
);

	// fault priority: open load over battery short over ground short
	function [2:0] osd_fault_code;
		input [2:0] combo;
		begin
			if (combo[2])
				osd_fault_code = `OSD_RES_OPEN_LOAD;
			else if (combo[1])
				osd_fault_code = `OSD_RES_SHORT_BAT;
			else if (combo[0])
				osd_fault_code = `OSD_RES_SHORT_GND;
			else
				osd_fault_code = `OSD_RES_NO_FAIL;
		end
	endfunction

	// count-down step that saturates at zero
	function [31:0] osd_dec;
		input [31:0] value;
		begin
			if (value == 32'h0)
				osd_dec = 32'h0;
			else
				osd_dec = value - 32'h1;
		end
	endfunction

	// synchroniser stages; the meta stage feeds only the sync stage
	reg        cs_meta_reg;
	reg        cs_sync_reg;
	reg        cs_last_reg;
	reg        sclk_meta_reg;
	reg        sclk_sync_reg;
	reg        sclk_last_reg;
	reg        sdi_meta_reg;
	reg        sdi_sync_reg;

	// spi datapath
	reg [15:0] shift_reg;
	reg [3:0]  bit_cnt_reg;
	reg        saw_clk_reg;
	reg        sdo_reg;
	reg        sdo_oe_reg;
	reg        pending_reg;
	reg        err_reg;
	reg        offstate_trigger_reg;

	// sequencer
	reg [1:0]  state_reg;
	reg [2:0]  result_reg;
	reg        sources_reg;
	reg        dis_last_reg;
	reg        hz_done_reg;
	reg [31:0] hz_cnt_reg;
	reg [31:0] tmr_cnt_reg;
	reg [31:0] tout_cnt_reg;
	reg [2:0]  combo_last_reg;

	wire       selected;
	wire       cs_fall;
	wire       cs_rise;
	wire       sclk_rise;
	wire       sclk_fall;
	wire       parity_ok;
	wire       addr_ok;
	wire       word_ok;
	wire [2:0] combo;
	wire       bad_state;
	wire [15:0] resp_word;

	// edges come from the sync and last stages only
	assign selected  = ~cs_sync_reg;                                // see (R26)
	assign cs_fall   = cs_last_reg & ~cs_sync_reg;
	assign cs_rise   = ~cs_last_reg & cs_sync_reg;
	assign sclk_rise = selected & sclk_sync_reg & ~sclk_last_reg;   // see (R7)
	assign sclk_fall = selected & ~sclk_sync_reg & sclk_last_reg;   // see (R7)

	// command checks on the word left in the shifter
	assign parity_ok = ^shift_reg;                                  // see (R23)
	assign addr_ok   = (shift_reg[`OSD_ADDR_MSB:`OSD_ADDR_LSB] == `OSD_ADDR_OFFDIAG);
	assign word_ok   = (bit_cnt_reg == 4'h0) & parity_ok & addr_ok; // see (R14)

	// answer word: address echoed, result in the low payload bits
	assign resp_word = {`OSD_ADDR_OFFDIAG, `OSD_RESP_PAD, result_reg}; // see (R12) (R22) (R24)

	assign combo     = {open_load_det, short_to_battery, short_to_ground};
	assign bad_state = ~disable_input | supply_undervoltage;

	assign spi_sdo               = sdo_reg;
	assign spi_sdo_oe            = sdo_oe_reg;
	assign diag_sources_on       = sources_reg;
	assign off_state_diag_result = result_reg;
	assign comm_error            = err_reg;
	assign offstate_trigger      = offstate_trigger_reg;

	// two-flop synchronisers plus one stage for edge detection
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cs_meta_reg   <= 1'b1;
			cs_sync_reg   <= 1'b1;
			cs_last_reg   <= 1'b1;
			sclk_meta_reg <= 1'b0;
			sclk_sync_reg <= 1'b0;
			sclk_last_reg <= 1'b0;
			sdi_meta_reg  <= 1'b0;
			sdi_sync_reg  <= 1'b0;
		end else begin
			cs_meta_reg   <= spi_cs_n;                              // see (R26)
			cs_sync_reg   <= cs_meta_reg;
			cs_last_reg   <= cs_sync_reg;
			sclk_meta_reg <= spi_sclk;
			sclk_sync_reg <= sclk_meta_reg;
			sclk_last_reg <= sclk_sync_reg;
			sdi_meta_reg  <= spi_sdi;
			sdi_sync_reg  <= sdi_meta_reg;
		end
	end

	// spi shifter; a single shift register also passes chained words through
	// the bit counter is four bits wide on purpose: it wraps every 16 clocks,
	// so any whole multiple of 16 ends at zero and longer chains need no width
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			shift_reg   <= `OSD_ZERO_WORD;
			bit_cnt_reg <= 4'h0;
			saw_clk_reg <= 1'b0;
			sdo_reg     <= 1'b0;
			sdo_oe_reg  <= 1'b0;                                    // see (R7)
			pending_reg <= 1'b0;                                    // see (R13)
			err_reg     <= 1'b0;
			offstate_trigger_reg    <= 1'b0;
		end else if (sw_reset) begin
			shift_reg   <= `OSD_ZERO_WORD;
			bit_cnt_reg <= 4'h0;
			saw_clk_reg <= 1'b0;
			sdo_reg     <= 1'b0;
			sdo_oe_reg  <= 1'b0;                                    // see (R7)
			pending_reg <= 1'b0;                                    // see (R13)
			err_reg     <= 1'b0;
			offstate_trigger_reg    <= 1'b0;
		end else begin
			err_reg    <= 1'b0;
			offstate_trigger_reg   <= 1'b0;
			sdo_oe_reg <= selected;                                 // see (R7)
			if (cs_fall) begin
				// the answer to the previous command is loaded here
				if (pending_reg)
					shift_reg <= resp_word;                         // see (R4)
				else
					shift_reg <= `OSD_ZERO_WORD;                    // see (R13) (R14)
				bit_cnt_reg <= 4'h0;
				saw_clk_reg <= 1'b0;
				sdo_reg     <= 1'b0;
			end else if (selected) begin
				// the master keeps sclk low at select edges, so no
				// shift can coincide with the load above
				if (sclk_rise)
					sdo_reg <= shift_reg[`OSD_WORD_BITS-1];         // see (R2) (R5)
				if (sclk_fall) begin
					shift_reg   <= {shift_reg[`OSD_WORD_BITS-2:0], sdi_sync_reg}; // see (R6)
					bit_cnt_reg <= bit_cnt_reg + 4'h1;              // see (R1)
					saw_clk_reg <= 1'b1;
				end
			end
			// execution waits for chip select to rise
			if (cs_rise && saw_clk_reg) begin                       // see (R9) (R10)
				if (word_ok) begin                                  // see (R11)
					pending_reg <= 1'b1;
					offstate_trigger_reg    <= shift_reg[`OSD_OFFSTATE_TRIGGER_BIT];
				end else begin
					pending_reg <= 1'b0;                            // see (R14)
					err_reg     <= 1'b1;
				end
			end
		end
	end

	// settle wait timer: restarts on disable rising edge or any reset
	// once expired it stays expired whatever disable does, until the next
	// rising edge; a low disable is caught by the state check instead
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dis_last_reg <= 1'b0;
			hz_cnt_reg   <= THZ_CYCLES;                             // see (R15)
			hz_done_reg  <= 1'b0;
		end else if (sw_reset) begin
			dis_last_reg <= disable_input;
			hz_cnt_reg   <= THZ_CYCLES;                             // see (R15)
			hz_done_reg  <= 1'b0;
		end else begin
			dis_last_reg <= disable_input;
			if (disable_input && !dis_last_reg) begin
				hz_cnt_reg  <= THZ_CYCLES;                          // see (R15)
				hz_done_reg <= 1'b0;
			end else if (!hz_done_reg) begin
				hz_cnt_reg <= osd_dec(hz_cnt_reg);
				if (hz_cnt_reg <= 32'h1)
					hz_done_reg <= 1'b1;
			end
		end
	end

	// diagnosis sequencer: settle, then filter with a parallel timeout
	// a trigger that arrives while a run is in progress is dropped, so a
	// restless master cannot restart the settling delay over and over
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg      <= `OSD_ST_IDLE;
			result_reg     <= `OSD_RES_RESET;                       // see (R21)
			sources_reg    <= 1'b0;
			tmr_cnt_reg    <= 32'h0;
			tout_cnt_reg   <= 32'h0;
			combo_last_reg <= 3'h0;
		end else if (sw_reset) begin
			state_reg      <= `OSD_ST_IDLE;
			result_reg     <= `OSD_RES_RESET;                       // see (R21)
			sources_reg    <= 1'b0;
			tmr_cnt_reg    <= 32'h0;
			tout_cnt_reg   <= 32'h0;
			combo_last_reg <= 3'h0;
		end else begin
			case (state_reg)
			`OSD_ST_IDLE: begin
				if (offstate_trigger_reg) begin                                 // see (R25)
					if (bad_state) begin
						result_reg <= `OSD_RES_BAD_STATE;           // see (R21)
					end else if (!hz_done_reg) begin
						result_reg <= `OSD_RES_HZ_WAIT;             // see (R21)
					end else begin
						result_reg  <= `OSD_RES_RUNNING;            // see (R21)
						sources_reg <= 1'b1;                        // see (R16)
						tmr_cnt_reg <= TDEL_CYCLES;
						state_reg   <= `OSD_ST_SETTLE;
					end
				end
			end
			`OSD_ST_SETTLE: begin
				if (bad_state) begin
					// bridge left the disabled state or supply undervoltage: give up the run
					result_reg  <= `OSD_RES_BAD_STATE;
					sources_reg <= 1'b0;
					state_reg   <= `OSD_ST_IDLE;
				end else if (tmr_cnt_reg <= 32'h1) begin            // see (R16)
					tmr_cnt_reg    <= TSTAB_CYCLES;
					tout_cnt_reg   <= TOUT_CYCLES;                  // see (R18)
					combo_last_reg <= combo;
					state_reg      <= `OSD_ST_FILTER;
				end else begin
					tmr_cnt_reg <= osd_dec(tmr_cnt_reg);
				end
			end
			`OSD_ST_FILTER: begin
				tout_cnt_reg <= osd_dec(tout_cnt_reg);
				if (bad_state) begin
					result_reg  <= `OSD_RES_BAD_STATE;
					sources_reg <= 1'b0;
					state_reg   <= `OSD_ST_IDLE;
				end else if (combo != combo_last_reg) begin
					// any edge of the combined input restarts the filter
					combo_last_reg <= combo;
					tmr_cnt_reg    <= TSTAB_CYCLES;                 // see (R17)
					if (tout_cnt_reg <= 32'h1) begin                // see (R18)
						sources_reg <= 1'b0;
						state_reg   <= `OSD_ST_IDLE;
					end
				end else if (tmr_cnt_reg <= 32'h1) begin            // see (R17)
					result_reg  <= osd_fault_code(combo);           // see (R19) (R20)
					sources_reg <= 1'b0;
					state_reg   <= `OSD_ST_IDLE;
				end else if (tout_cnt_reg <= 32'h1) begin           // see (R18)
					// restless input: stop, result stays at running
					sources_reg <= 1'b0;
					state_reg   <= `OSD_ST_IDLE;
				end else begin
					tmr_cnt_reg <= osd_dec(tmr_cnt_reg);
				end
			end
			default: begin
				state_reg   <= `OSD_ST_IDLE;
				sources_reg <= 1'b0;
			end
			endcase
		end
	end

endmodule

// *** src/osd_spi_defs.vh ***
// constants for the spi slave front end and the off-state diagnosis sequencer
// assumes a single 125 MHz system clock; all timings are derived from it
`ifndef OSD_SPI_DEFS_VH
`define OSD_SPI_DEFS_VH

// serial word layout
`define OSD_WORD_BITS      16
`define OSD_ADDR_MSB       15
`define OSD_ADDR_LSB       12
`define OSD_OFFSTATE_TRIGGER_BIT       1
`define OSD_RESP_PAD_BITS  9
`define OSD_RESP_PAD       9'h000
`define OSD_ZERO_WORD      16'h0000

// command address of the off-state diagnosis frame
`define OSD_ADDR_OFFDIAG   4'h9

// off-state result codes
`define OSD_RES_OPEN_LOAD  3'h1
`define OSD_RES_SHORT_BAT  3'h2
`define OSD_RES_SHORT_GND  3'h3
`define OSD_RES_NO_FAIL    3'h4
`define OSD_RES_BAD_STATE  3'h5
`define OSD_RES_HZ_WAIT    3'h6
`define OSD_RES_RUNNING    3'h7
`define OSD_RES_RESET      3'h7

// sequencer state codes
`define OSD_ST_IDLE        2'h0
`define OSD_ST_SETTLE      2'h1
`define OSD_ST_FILTER      2'h2

// timing, figures in their own units
`define OSD_CLK_MHZ        125
`define OSD_THZ_MS         250
`define OSD_TDEL_US        749
`define OSD_TSTAB_US       40
`define OSD_TOUT_US        400

// timing in clock cycles
`define OSD_THZ_CYC        (`OSD_THZ_MS * 1000 * `OSD_CLK_MHZ)
`define OSD_TDEL_CYC       (`OSD_TDEL_US * `OSD_CLK_MHZ)
`define OSD_TSTAB_CYC      (`OSD_TSTAB_US * `OSD_CLK_MHZ)
`define OSD_TOUT_CYC       (`OSD_TOUT_US * `OSD_CLK_MHZ)

`endif

// *** tb/osd_spi_props.sv ***
// port checker for the spi slave and off-state diagnosis sequencer
// bound from the testbench top; one clock domain, async low reset
`timescale 1ns/100ps
module osd_spi_props #(
	parameter int TDEL_CYCLES  = 50,
	parameter int TSTAB_CYCLES = 20,
	parameter int TOUT_CYCLES  = 100
) (
	input wire       clock,
	input wire       rstn,
	input wire       sw_reset,
	input wire       spi_cs_n,
	input wire       spi_sclk,
	input wire       spi_sdi,
	input wire       spi_sdo,
	input wire       spi_sdo_oe,
	input wire       disable_input,
	input wire       supply_undervoltage,
	input wire       open_load_det,
	input wire       short_to_battery,
	input wire       short_to_ground,
	input wire       diag_sources_on,
	input wire [2:0] off_state_diag_result,
	input wire       comm_error,
	input wire       offstate_trigger
);
	int unsigned on_cnt;

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn || sw_reset);

	// cycles with sources on, a counter since the bounds exceed a repetition
	always @(posedge clock or negedge rstn) begin
		if (!rstn)
			on_cnt <= 0;
		else if (!diag_sources_on)
			on_cnt <= 0;
		else
			on_cnt <= on_cnt + 1;
	end

	sdo_idle_off_a: assert property (spi_cs_n [*5] |-> !spi_sdo_oe)
		else $error("sdo enabled while deselected");
	sdo_sel_on_a: assert property ($fell(spi_cs_n) |-> ##[1:4] spi_sdo_oe)
		else $error("sdo not enabled after select");
	pulse_at_rise_a: assert property ((comm_error || offstate_trigger) |->
		$past(spi_cs_n, 2) && !$past(spi_cs_n, 7))
		else $error("frame pulse without select rise");
	err_single_a: assert property (comm_error |-> !offstate_trigger ##1 !comm_error)
		else $error("error pulse malformed");
	src_start_a: assert property ($rose(diag_sources_on) |->
		$past(offstate_trigger) && off_state_diag_result == 3'h7)
		else $error("sources on without trigger");
	settle_min_a: assert property ($fell(diag_sources_on) && off_state_diag_result < 3'h5
		|-> on_cnt >= TDEL_CYCLES + TSTAB_CYCLES - 2)
		else $error("diagnosis latched too early");
	tout_max_a: assert property (diag_sources_on |-> on_cnt <= TDEL_CYCLES + TOUT_CYCLES + 8)
		else $error("sequence outlived its timeout");
	res_cause_a: assert property ($changed(off_state_diag_result) |->
		$past(offstate_trigger) || $fell(diag_sources_on) || $rose(diag_sources_on)
		|| $past(sw_reset))
		else $error("result changed without cause");
	sdo_shift_a: assert property (spi_sdo_oe && $past(spi_sdo_oe) && !spi_cs_n
		&& $changed(spi_sdo) |-> $past(spi_sclk, 2) && !$past(spi_sclk, 6))
		else $error("sdo moved off a clock rise");
endmodule

// *** tb/osd_spi_master.sv ***
// spi master model: drives select, clock and data-in, collects sdo
// all changes at the falling system clock edge; tasks called by the bench
`timescale 1ns/100ps
module osd_spi_master (
	input  wire         clock,
	input  wire         spi_sdo,
	input  wire         spi_sdo_oe,
	output logic        spi_cs_n,
	output logic        spi_sclk,
	output logic        spi_sdi,
	output logic [31:0] rx_word,
	output logic        rx_done
);
	// a floating sdo reads as the inverse, so stale bits never match
	wire sdo_pin = spi_sdo_oe ? spi_sdo : ~spi_sdo;

	// idle levels, select and clock are ours alone
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
		rx_word = 32'h0;
		rx_done = 1'b0;
	end

	// one frame of n bits, hp system clocks per clock phase (at least 5)
	task automatic xfer(input logic [31:0] w, input int n, input int hp);
		int i;
		rx_word = 32'h0;
		spi_sdi = 1'($urandom); // noise while deselected
		spi_sclk = 1'b1;
		repeat (hp) @(negedge clock);
		spi_sclk = 1'b0;
		repeat (hp) @(negedge clock);
		spi_cs_n = 1'b0;
		repeat (2 * hp) @(negedge clock);
		for (i = n - 1; i >= 0; i--) begin
			spi_sclk = 1'b1;
			spi_sdi = w[i];
			repeat (hp) @(negedge clock);
			spi_sclk = 1'b0;
			rx_word = {rx_word[30:0], sdo_pin};
			repeat (hp) @(negedge clock);
		end
		spi_cs_n = 1'b1;
		spi_sdi = ~spi_sdi;
		repeat (hp) @(negedge clock);
		rx_done = (n > 0);
		@(negedge clock);
		rx_done = 1'b0;
	endtask
endmodule

// *** tb/tb_spi_slave_offstate_diag.sv ***
// top testbench: spi master model drives frames, a monitor checks answers
// short timing parameters; the checker is bound below the module
`timescale 1ns/100ps
module tb_spi_slave_offstate_diag;
	logic        clock, rstn, sw_reset, disable_input, supply_undervoltage;
	logic        open_load_det, short_to_battery, short_to_ground;
	logic        spi_cs_n, spi_sclk, spi_sdi, rx_done;
	logic [31:0] rx_word;
	wire         spi_sdo, spi_sdo_oe, diag_sources_on, comm_error, offstate_trigger;
	wire  [2:0]  off_state_diag_result;
	logic [31:0] exp_q[$];
	int          err_total = 0;
	int          checks = 0;

	osd_spi_slave #(.THZ_CYCLES(32'h5DC), .TDEL_CYCLES(32'h32), .TSTAB_CYCLES(32'h14),
		.TOUT_CYCLES(32'h64)) i_dut (.*);
	osd_spi_master i_mst (.*);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: sdo word %h, expected %h", $time, got, exp);
		end
	endtask

	// an empty queue expects unknown, so a surplus answer fails
	always @(posedge rx_done)
		cmp(rx_word, exp_q.size() ? exp_q.pop_front() : 32'hXXXXXXXX);

	function automatic logic [15:0] cmd(input logic [3:0] a, input logic t, input logic ok);
		logic [15:0] r;
		r = {a, 10'($urandom), t, 1'b0};
		r[0] = (~^r[15:1]) ^ !ok;
		return r;
	endfunction

	function automatic logic [31:0] ans(input logic [2:0] c);
		return {16'h0000, 4'h9, 9'h000, c};
	endfunction

	function automatic logic [2:0] pri(input logic [2:0] c);
		return c[2] ? 3'h1 : c[1] ? 3'h2 : c[0] ? 3'h3 : 3'h4;
	endfunction

	task automatic tx(input logic [31:0] w, input int n, input logic [31:0] e);
		if (n > 0)
			exp_q.push_back(e);
		i_mst.xfer(w, n, 5 + $urandom % 3);
	endtask

	task automatic note(input string s);
		$display("test done: %s", s);
	endtask

	task automatic report_and_stop;
		if (exp_q.size() != 0)
			err_total++;
		$display("counts: %0d checks, %0d mismatches", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (60000) @(posedge clock);
		err_total++;
		$display("wrong value at %0t: run did not finish", $time);
		report_and_stop;
	end

	// main sequence
	initial begin
		logic [2:0]  p;
		logic [15:0] j;
		int          i;
		{rstn, sw_reset, disable_input, supply_undervoltage} = 4'h0;
		{open_load_det, short_to_battery, short_to_ground} = 3'h0;
		void'($urandom(32'h1B442F88));
		repeat (12) @(negedge clock);
		rstn = 1'b1;
		repeat (3) @(negedge clock);
		disable_input = 1'b1;
		tx(cmd(4'h9, 1, 1), 16, 32'h0);
		tx(cmd(4'h9, 0, 1), 16, ans(3'h6));
		disable_input = 1'b0;
		tx(cmd(4'h9, 1, 1), 16, ans(3'h6));
		disable_input = 1'b1;
		tx(cmd(4'h9, 1, 1), 16, ans(3'h5));
		repeat (700) @(negedge clock);
		tx(cmd(4'h9, 1, 1), 16, ans(3'h6));
		repeat (800) @(negedge clock);
		supply_undervoltage = 1'b1;
		tx(cmd(4'h9, 1, 1), 16, ans(3'h6));
		supply_undervoltage = 1'b0;
		note("hold-off and state");
		p = 3'h5;
		for (i = 0; i < 8; i++) begin
			{open_load_det, short_to_battery, short_to_ground} = 3'(i);
			tx(cmd(4'h9, 1, 1), 16, ans(p));
			tx(cmd(4'h9, 0, 1), 16, ans(3'h7));
			p = pri(3'(i));
			tx(cmd(4'h9, 0, 1), 16, ans(p));
		end
		note("result codes");
		// detector edges inside the filter window restart it
		{open_load_det, short_to_battery, short_to_ground} = 3'h0;
		tx(cmd(4'h9, 1, 1), 16, ans(p));
		repeat (50) @(negedge clock);
		for (i = 0; i < 3; i++) begin
			open_load_det = ~open_load_det;
			repeat (10) @(negedge clock);
		end
		repeat (30) @(negedge clock);
		tx(cmd(4'h9, 1, 1), 16, ans(3'h1));
		for (i = 0; i < 30; i++) begin
			open_load_det = ~open_load_det;
			repeat (8) @(negedge clock);
		end
		tx(cmd(4'h9, 0, 1), 16, ans(3'h7));
		note("filter and timeout");
		tx(cmd(4'h9, 0, 1), 15, ans(3'h7) >> 1);
		tx(cmd(4'h9, 0, 1), 16, 32'h0);
		tx(cmd(4'h9, 0, 0), 16, ans(3'h7));
		tx(cmd(4'h5, 0, 1), 16, 32'h0);
		tx(cmd(4'h9, 0, 1), 16, 32'h0);
		tx(32'h0, 0, 32'h0);
		tx(cmd(4'h9, 0, 1), 16, ans(3'h7));
		j = 16'($urandom);
		tx({j, cmd(4'h9, 0, 1)}, 32, {ans(3'h7), j});
		tx(cmd(4'h9, 0, 1), 16, ans(3'h7));
		note("errors and chain");
		@(negedge clock);
		sw_reset = 1'b1;
		@(negedge clock);
		sw_reset = 1'b0;
		tx(cmd(4'h9, 1, 1), 16, 32'h0);
		tx(cmd(4'h9, 0, 1), 16, ans(3'h6));
		note("software reset");
		report_and_stop;
	end
endmodule

bind osd_spi_slave osd_spi_props #(.TDEL_CYCLES(TDEL_CYCLES), .TSTAB_CYCLES(TSTAB_CYCLES),
	.TOUT_CYCLES(TOUT_CYCLES)) i_props (.*);
